/* File: core/hst_pkg.sv */
/*
  Constants for the high-side switch timer and control block: register
  addresses, field positions, codes and timer tick figures.
  Assumes a 20 MHz ref_clk and 7-bit register addresses from the serial
  frame decoder.
*/
package hst_pkg;

  // ------------------------------------------------------------
  // register addresses
  // ------------------------------------------------------------
  localparam logic [6:0] ADDR_TIMER_A = 7'h0C;
  localparam logic [6:0] ADDR_TIMER_B = 7'h0D;
  localparam logic [6:0] ADDR_SHUTDOWN = 7'h10;
  localparam logic [6:0] ADDR_SEL_LOWER = 7'h14;
  localparam logic [6:0] ADDR_SEL_UPPER = 7'h15;

  // ------------------------------------------------------------
  // field positions and masks
  // ------------------------------------------------------------
  localparam int ON_LSB = 4;
  localparam int PER_LSB = 0;
  localparam int SEL_LO_LSB = 0;
  localparam int SEL_HI_LSB = 4;
  localparam int OV_DIS_BIT = 6;
  localparam int UV_DIS_BIT = 5;
  localparam int RECOVER_BIT = 4;
  localparam logic [7:0] TIMER_MASK = 8'h77;
  localparam logic [7:0] SHUTDOWN_MASK = 8'h70;
  localparam logic [7:0] SEL_MASK = 8'h77;
  localparam logic [7:0] RESET_VALUE = 8'h00;

  // ------------------------------------------------------------
  // codes
  // ------------------------------------------------------------
  localparam logic [2:0] ON_LOW = 3'h0;
  localparam logic [2:0] ON_HIGH = 3'h6;
  localparam logic [2:0] SEL_OFF = 3'h0;
  localparam logic [2:0] SEL_ON = 3'h1;
  localparam logic [2:0] SEL_TIMER_A = 3'h2;
  localparam logic [2:0] SEL_TIMER_B = 3'h3;
  localparam logic [2:0] SEL_DUTY_ONE = 3'h4;
  localparam logic [2:0] SEL_DUTY_TWO = 3'h5;

  // ------------------------------------------------------------
  // timing: one tick is 0.1 ms
  // ------------------------------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int TICK_US = 100;
  localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
  localparam int TICK_W = 12;
  localparam int CNT_W = 15;

  // on-time in ticks for a code (0 when not running)
  function automatic logic [CNT_W-1:0] on_ticks(input logic [2:0] code);
    case (code)
      3'h1: on_ticks = 15'h0001;
      3'h2: on_ticks = 15'h0003;
      3'h3: on_ticks = 15'h000A;
      3'h4: on_ticks = 15'h0064;
      3'h5: on_ticks = 15'h00C8;
      default: on_ticks = 15'h0000;
    endcase
  endfunction

  // period in ticks for a code; reserved code falls back to 10 ms
  function automatic logic [CNT_W-1:0] per_ticks(input logic [2:0] code);
    case (code)
      3'h1: per_ticks = 15'h00C8;
      3'h2: per_ticks = 15'h01F4;
      3'h3: per_ticks = 15'h03E8;
      3'h4: per_ticks = 15'h07D0;
      3'h5: per_ticks = 15'h2710;
      3'h6: per_ticks = 15'h4E20;
      default: per_ticks = 15'h0064;
    endcase
  endfunction

endpackage

/* File: core/hst_switch_ctrl.sv */
/*
  High-side switch timer and control: two cyclic timers, four switch
  source selects, supply fault shutdown and recovery, register port.
  Assumes the serial frame decoder hands over single register accesses
  with a 7-bit address, and that fault and restart inputs are
  synchronous to ref_clk.
*/
// Overview of operation
// - timer b on-time bits 6:4, 000 off low
// - code 110 holds high; 111 reserved
// - period bits 2:0, 10 ms up to 2 s
// - timer starts when running on-time written
// - restart clear with cyclic sense clears timers
// - timer b register at 0x0d, bits 7,3 reserved
// - reserved bits always read zero
// - bit 6 set suppresses overvoltage shutdown
// - bit 5 set suppresses undervoltage shutdown
// - bit 4 restores pre-fault state after fault
// - shutdown register at 0x10, bits 6:4 only
// - lower select register 0x14, switches one, two
// - upper select register 0x15, switches three, four
// - overcurrent or overtemperature clears switch select
// - all registers reset to zero
// - timer a register at 0x0c, same layout
`timescale 1ns/1ns
module hst_switch_ctrl #(
  parameter int TICK_CYCLES = hst_pkg::TICK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic soft_reset,
  input wire logic reg_wr,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic duty_source_one,
  input wire logic duty_source_two,
  input wire logic [3:0] overcurrent,
  input wire logic [3:0] overtemp,
  input wire logic supply_ov,
  input wire logic supply_uv,
  input wire logic restart_clear,
  input wire logic cyclic_sense,
  output logic [3:0] high_side_output
);

  // ------------------------------------------------------------
  // register storage and decode
  // ------------------------------------------------------------
  logic [7:0] timer_q [2];
  logic [7:0] timer_d [2];
  logic [7:0] shutdown_q;
  logic [7:0] shutdown_d;
  logic [2:0] sel_q [4];
  logic [2:0] sel_d [4];
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic clr;
  logic wr_timer [2];
  logic wr_shutdown;
  logic wr_lower;
  logic wr_upper;
  logic restart_wipe;
  logic fault_off;
  logic fault_latch_off;
  logic [3:0] hw_clear;
  logic [3:0] src_level;
  logic [1:0] timer_out;
  // prescaler width from the package
  localparam int TICK_W = hst_pkg::TICK_W;
  logic [TICK_W-1:0] pre_q;
  logic [TICK_W-1:0] pre_d;
  logic tick;

  assign clr = rst | soft_reset;

  assign wr_timer[0] = reg_wr && (reg_addr == hst_pkg::ADDR_TIMER_A);
  assign wr_timer[1] = reg_wr && (reg_addr == hst_pkg::ADDR_TIMER_B);
  assign wr_shutdown = reg_wr && (reg_addr == hst_pkg::ADDR_SHUTDOWN);
  assign wr_lower = reg_wr && (reg_addr == hst_pkg::ADDR_SEL_LOWER);
  assign wr_upper = reg_wr && (reg_addr == hst_pkg::ADDR_SEL_UPPER);

  // restart wipe of selects and timer settings
  assign restart_wipe = restart_clear & cyclic_sense;

  assign fault_off =
    (supply_ov & ~shutdown_q[hst_pkg::OV_DIS_BIT]) |
    (supply_uv & ~shutdown_q[hst_pkg::UV_DIS_BIT]);

  // without recovery the selects are dropped for good
  assign fault_latch_off = fault_off & ~shutdown_q[hst_pkg::RECOVER_BIT];

  assign hw_clear = overcurrent | overtemp;

  // ------------------------------------------------------------
  // register next values; hardware clears win over writes
  // ------------------------------------------------------------
  // reserved bits masked on write
  assign shutdown_d = wr_shutdown ?
    (reg_wdata & hst_pkg::SHUTDOWN_MASK) : shutdown_q;

  // timer fields, also wiped in restart
  always_comb begin
    for (int t = 0; t < 2; t++) begin
      timer_d[t] = timer_q[t];
      if (wr_timer[t]) begin
        timer_d[t] = reg_wdata & hst_pkg::TIMER_MASK;
      end
      if (restart_wipe) begin
        timer_d[t] = hst_pkg::RESET_VALUE;
      end
    end
  end

  always_comb begin
    for (int s = 0; s < 4; s++) begin
      sel_d[s] = sel_q[s];
      if ((s < 2) ? wr_lower : wr_upper) begin
        sel_d[s] = (s % 2 == 0) ?
          reg_wdata[hst_pkg::SEL_LO_LSB +: 3] :
          reg_wdata[hst_pkg::SEL_HI_LSB +: 3];
      end
      if (hw_clear[s] | restart_wipe | fault_latch_off) begin
        sel_d[s] = hst_pkg::SEL_OFF;
      end
    end
  end

  // read mux, unmapped and reserved read zero
  assign rdata_d =
    (reg_addr == hst_pkg::ADDR_TIMER_A) ? timer_q[0] :
    (reg_addr == hst_pkg::ADDR_TIMER_B) ? timer_q[1] :
    (reg_addr == hst_pkg::ADDR_SHUTDOWN) ? shutdown_q :
    (reg_addr == hst_pkg::ADDR_SEL_LOWER) ? {1'b0, sel_q[1], 1'b0, sel_q[0]} :
    (reg_addr == hst_pkg::ADDR_SEL_UPPER) ? {1'b0, sel_q[3], 1'b0, sel_q[2]} :
    hst_pkg::RESET_VALUE;

  always_ff @(posedge ref_clk) begin
    if (clr) begin
      shutdown_q <= hst_pkg::RESET_VALUE;
      rdata_q <= hst_pkg::RESET_VALUE;
      for (int i = 0; i < 2; i++) begin
        timer_q[i] <= hst_pkg::RESET_VALUE;
      end
      for (int i = 0; i < 4; i++) begin
        sel_q[i] <= hst_pkg::SEL_OFF;
      end
    end else begin
      shutdown_q <= shutdown_d;
      rdata_q <= rdata_d;
      timer_q <= timer_d;
      sel_q <= sel_d;
    end
  end

  assign reg_rdata = rdata_q;

  // ------------------------------------------------------------
  // 0.1 ms tick prescaler
  // ------------------------------------------------------------
  assign tick = (pre_q == TICK_W'(TICK_CYCLES - 1));
  assign pre_d = tick ? '0 : pre_q + TICK_W'(1);

  always_ff @(posedge ref_clk) begin
    if (clr) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_d;
    end
  end

  // ------------------------------------------------------------
  // cyclic timers
  // ------------------------------------------------------------
  // timer a, same layout as timer b
  hst_cycle_timer u_timer_a (
    .ref_clk(ref_clk),
    .clr(clr),
    .tick(tick),
    .restart(wr_timer[0]),
    .cfg(timer_q[0]),
    .level(timer_out[0])
  );

  // timer b, started by its own writes
  hst_cycle_timer u_timer_b (
    .ref_clk(ref_clk),
    .clr(clr),
    .tick(tick),
    .restart(wr_timer[1]),
    .cfg(timer_q[1]),
    .level(timer_out[1])
  );

  // ------------------------------------------------------------
  // switch source selection and output stage
  // ------------------------------------------------------------
  // one source pick per switch, reserved codes off
  for (genvar s = 0; s < 4; s++) begin : g_pick
    hst_source_pick u_pick (
      .sel(sel_q[s]),
      .timer_a(timer_out[0]),
      .timer_b(timer_out[1]),
      .duty_one(duty_source_one),
      .duty_two(duty_source_two),
      .level(src_level[s])
    );
  end

  // gate outputs while the supply fault stands
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      high_side_output <= '0;
    end else begin
      high_side_output <= fault_off ? '0 : src_level;
    end
  end

endmodule

// ------------------------------------------------------------
// one cyclic timer: tick counter and output level
// ------------------------------------------------------------
module hst_cycle_timer #(
  parameter int CNT_W = hst_pkg::CNT_W
) (
  input wire logic ref_clk,
  input wire logic clr,
  input wire logic tick,
  input wire logic restart,
  input wire logic [7:0] cfg,
  output logic level
);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [2:0] on_code;
  logic [2:0] per_code;
  logic [CNT_W-1:0] on_len;
  logic [CNT_W-1:0] per_len;
  logic running;
  logic per_end;

  assign on_code = cfg[hst_pkg::ON_LSB +: 3];
  assign per_code = cfg[hst_pkg::PER_LSB +: 3];
  assign on_len = CNT_W'(hst_pkg::on_ticks(on_code));
  assign per_len = CNT_W'(hst_pkg::per_ticks(per_code));
  assign running = (on_len != '0);
  // last tick of the period
  assign per_end = (cnt_q >= per_len - CNT_W'(1));

  // write restarts the cycle at its start
  assign cnt_d =
    (restart | ~running) ? '0 :
    ~tick ? cnt_q :
    per_end ? '0 :
    cnt_q + CNT_W'(1);

  // tick count within the period
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // high for on-time, or held level
  assign level = running ? (cnt_q < on_len) :
                 (on_code == hst_pkg::ON_HIGH);

endmodule

// ------------------------------------------------------------
// source pick for one switch
// ------------------------------------------------------------
module hst_source_pick (
  input wire logic [2:0] sel,
  input wire logic timer_a,
  input wire logic timer_b,
  input wire logic duty_one,
  input wire logic duty_two,
  output logic level
);

  logic pick_on;
  logic pick_timer_a;
  logic pick_timer_b;
  logic pick_duty_one;
  logic pick_duty_two;

  // one named wire per source code
  assign pick_on = (sel == hst_pkg::SEL_ON);
  assign pick_timer_a = (sel == hst_pkg::SEL_TIMER_A);
  assign pick_timer_b = (sel == hst_pkg::SEL_TIMER_B);
  assign pick_duty_one = (sel == hst_pkg::SEL_DUTY_ONE);
  assign pick_duty_two = (sel == hst_pkg::SEL_DUTY_TWO);

  // off and reserved codes match no wire and drive low
  assign level =
    pick_on |
    (pick_timer_a & timer_a) |
    (pick_timer_b & timer_b) |
    (pick_duty_one & duty_one) |
    (pick_duty_two & duty_two);

endmodule

/* File: verification/hst_switch_ctrl_props.sv */
/*
  port checker for hst_switch_ctrl: register masks, fault clears, resets.
  assumes the registered read port and TICK_CYCLES of the bench.
*/
`timescale 1ns/1ns
module hst_switch_ctrl_props (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic soft_reset,
  input wire logic reg_wr,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [3:0] overcurrent,
  input wire logic [3:0] overtemp,
  input wire logic [3:0] high_side_output
);
  // ----------------------------------------
  // port properties
  // ----------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  chk_timer_reserved: assert property ($past(reg_addr) == 7'h0d |->
    (reg_rdata & 8'h88) == 8'h00) else $error("timer reserved bit set");
  chk_shut_reserved: assert property ($past(reg_addr) == 7'h10 |->
    (reg_rdata & 8'h8f) == 8'h00) else $error("shutdown reserved bit set");
  chk_sel_reserved: assert property (
    $past(reg_addr) inside {7'h14, 7'h15} |-> !reg_rdata[7] && !reg_rdata[3])
    else $error("select reserved bit set");
  chk_shut_readback: assert property (
    (reg_wr && reg_addr == 7'h10 && !soft_reset) ##1
    (!reg_wr && reg_addr == 7'h10 && !soft_reset)
    |=> reg_rdata == ($past(reg_wdata, 2) & 8'h70))
    else $error("shutdown readback wrong");
  chk_oc_clears: assert property (overcurrent[1] [*3]
    |-> !high_side_output[1]) else $error("overcurrent left switch on");
  chk_ot_clears: assert property (overtemp[2] [*3]
    |-> !high_side_output[2]) else $error("overtemp left switch on");
  chk_soft_clear: assert property (soft_reset |=>
    high_side_output == 4'h0 && reg_rdata == 8'h00)
    else $error("soft reset left state");
  chk_hard_clear: assert property (disable iff (1'b0) $fell(rst) |->
    high_side_output == 4'h0 && reg_rdata == 8'h00)
    else $error("reset left state");
endmodule
bind hst_switch_ctrl hst_switch_ctrl_props props (.ref_clk, .rst,
  .soft_reset, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .overcurrent,
  .overtemp, .high_side_output);

/* File: verification/hst_mcu_model.sv */
/*
  controller model: single register writes and registered reads.
  assumes the block takes a write on the rising edge with reg_wr high.
*/
`timescale 1ns/1ns
module hst_mcu_model (
  input wire logic ref_clk,
  input wire logic [7:0] reg_rdata,
  output logic reg_wr,
  output logic [6:0] reg_addr,
  output logic [7:0] reg_wdata
);
  // idle bus at time zero
  initial begin
    reg_wr = 1'b0;
    reg_addr = 7'h00;
    reg_wdata = 8'h00;
  end
  // one write, strobe for one edge, data scrambled after
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask
  // read: address held until the answer is taken
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    repeat (2) @(posedge ref_clk);
    d = reg_rdata;
  endtask
endmodule

/* File: verification/tb_top.sv */
/*
  self-checking bench for hst_switch_ctrl with TICK_CYCLES of 4.
  registers go through the controller model; faults come from here.
*/
`timescale 1ns/1ns
module tb_top;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic soft_reset = 1'b0;
  logic [3:0] oc = 4'h0;
  logic [3:0] ot = 4'h0;
  logic ov = 1'b0;
  logic uv = 1'b0;
  logic rc = 1'b0;
  logic cs = 1'b0;
  logic du1 = 1'b1;
  logic du2 = 1'b0;
  logic reg_wr;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic [3:0] hso;
  logic [7:0] e_sel = 8'h16;
  int n_fail = 0;
  int cmp_count = 0;
  int n;
  // clock; duty sources start at one and zero
  always #25 ref_clk = ~ref_clk;
  hst_switch_ctrl #(.TICK_CYCLES(4)) dut (.ref_clk, .rst, .soft_reset,
    .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .duty_source_one(du1),
    .duty_source_two(du2), .overcurrent(oc), .overtemp(ot),
    .supply_ov(ov), .supply_uv(uv), .restart_clear(rc),
    .cyclic_sense(cs), .high_side_output(hso));
  hst_mcu_model mcu (.ref_clk, .reg_rdata, .reg_wr, .reg_addr, .reg_wdata);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] v);
    cmp_count++;
    if (v !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", s, e, v);
    end
  endtask
  task automatic rdc(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] v;
    mcu.rd(a, v);
    chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, v});
  endtask
  task automatic outs(input logic [3:0] e);
    repeat (3) @(posedge ref_clk);
    chk("outputs", {12'h000, e}, {12'h000, hso});
  endtask
  task automatic span(input logic v, input int lim, output int k);
    k = 0;
    while (hso[0] !== v) begin
      @(posedge ref_clk);
      k++;
      if (k > lim) begin
        n_fail++;
        tally_and_finish();
      end
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_masks;
    foreach (e_sel[i]) rdc(7'h0d + 7'(i), 8'h00);
    mcu.wr(7'h0d, 8'hee);
    rdc(7'h0d, 8'h66);
    mcu.wr(7'h10, 8'hff);
    mcu.wr(7'h11, 8'h00);
    rdc(7'h10, 8'h70);
    mcu.wr(7'h14, 8'hff);
    rdc(7'h14, 8'h77);
    mcu.wr(7'h15, 8'hff);
    rdc(7'h15, 8'h77);
    mcu.wr(7'h10, 8'h00);
    mcu.wr(7'h15, 8'h00);
  endtask
  task automatic t_select;
    mcu.wr(7'h0c, 8'h60);
    mcu.wr(7'h0d, 8'h00);
    for (int c = 0; c < 8; c++) begin
      mcu.wr(7'h14, 8'(c));
      outs({3'h0, e_sel[c]});
    end
    du1 <= 1'b0;
    du2 <= 1'b1;
    mcu.wr(7'h14, 8'h54);
    outs(4'h2);
    mcu.wr(7'h14, 8'h03);
    outs(4'h0);
    mcu.wr(7'h0d, 8'h60);
    outs(4'h1);
  endtask
  task automatic t_timer;
    mcu.wr(7'h0d, 8'h21);
    span(1'b1, 900, n);
    span(1'b0, 20, n);
    span(1'b1, 900, n);
    span(1'b0, 20, n);
    chk("on cycles", 16'h000c, 16'(n));
    span(1'b1, 900, n);
    chk("off cycles", 16'h0314, 16'(n));
  endtask
  task automatic t_fault;
    mcu.wr(7'h14, 8'h11);
    mcu.wr(7'h10, 8'h10);
    ov <= 1'b1;
    outs(4'h0);
    ov <= 1'b0;
    outs(4'h3);
    mcu.wr(7'h10, 8'h60);
    ov <= 1'b1;
    uv <= 1'b1;
    outs(4'h3);
    ov <= 1'b0;
    uv <= 1'b0;
    mcu.wr(7'h10, 8'h00);
    uv <= 1'b1;
    outs(4'h0);
    uv <= 1'b0;
    outs(4'h0);
    rdc(7'h14, 8'h00);
    mcu.wr(7'h14, 8'h11);
    mcu.wr(7'h15, 8'h01);
    oc <= 4'h2;
    ot <= 4'h4;
    outs(4'h1);
    oc <= 4'h0;
    ot <= 4'h0;
    rdc(7'h14, 8'h01);
    rdc(7'h15, 8'h00);
  endtask
  task automatic t_restart;
    mcu.wr(7'h0d, 8'h21);
    mcu.wr(7'h15, 8'h11);
    rc <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rc <= 1'b0;
    rdc(7'h0d, 8'h21);
    cs <= 1'b1;
    rc <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rc <= 1'b0;
    cs <= 1'b0;
    rdc(7'h0d, 8'h00);
    rdc(7'h15, 8'h00);
    mcu.wr(7'h10, 8'h70);
    soft_reset <= 1'b1;
    @(posedge ref_clk);
    soft_reset <= 1'b0;
    rdc(7'h10, 8'h00);
  endtask
  // main sequence
  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    t_masks();
    t_select();
    t_timer();
    t_fault();
    t_restart();
    tally_and_finish();
  end
endmodule
